// file: logic/mcrb_dac_bank.v
`timescale 1ns/1ns
`include "mcrb_map.vh"
module mcrb_dac_bank (
  input  wire        i_mclk,
  input  wire        i_nrst,
  input  wire        i_code_wr,
  input  wire        i_clr_wr,
  input  wire [3:0]  i_idx,
  input  wire [11:0] i_wdata,
  input  wire        i_load,
  input  wire        i_clear,
  input  wire [3:0]  i_rd_idx,
  output wire [11:0] o_code,
  output wire [11:0] o_clr_level,
  output reg  [143:0] o_latch
);
  reg [11:0] code_q [0:11];
  reg [11:0] clr_q  [0:11];
  integer    k;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < `MCRB_N_DAC; k = k + 1) begin
        code_q[k] <= `MCRB_RST_CODE;
        clr_q[k]  <= `MCRB_RST_CODE;
      end
      o_latch <= {144{1'b0}};
    end else begin
      if (i_code_wr)
        code_q[i_idx] <= i_wdata;
      if (i_clr_wr)
        clr_q[i_idx] <= i_wdata;
      // Clear outranks a load in the same cycle: it is the safe state
      for (k = 0; k < `MCRB_N_DAC; k = k + 1) begin
        if (i_clear)
          o_latch[k*12 +: 12] <= clr_q[k];
        else if (i_load)
          o_latch[k*12 +: 12] <= code_q[k];
      end
    end
  end

  assign o_code      = code_q[i_rd_idx];
  assign o_clr_level = clr_q[i_rd_idx];
endmodule

// file: logic/mcrb_map.vh
`ifndef MCRB_MAP_VH
`define MCRB_MAP_VH
// Register addresses
`define MCRB_ADDR_ETA     7'h21
`define MCRB_ADDR_ADC0    7'h23
`define MCRB_ADDR_ADC15   7'h32
`define MCRB_ADDR_DAC0    7'h33
`define MCRB_ADDR_DAC11   7'h3e
`define MCRB_ADDR_CLR0    7'h3f
`define MCRB_ADDR_CLR11   7'h4a
`define MCRB_ADDR_GPIO    7'h4b
`define MCRB_ADDR_CTRL    7'h4c
// Reset values
`define MCRB_RST_GPIO     8'hff
`define MCRB_RST_CTRL     16'h2000
`define MCRB_RST_CODE     12'h000
`define MCRB_RST_ETA      8'h00
// Main control fields
`define MCRB_B_REPEAT_CONVERSION_SEL      13
`define MCRB_B_SOFT_CONVERT_START      12
`define MCRB_B_SYNC_OUTPUT_LOAD      11
`define MCRB_B_REFSEL     10
`define MCRB_B_ALMEN      9
`define MCRB_B_RDY        7
`define MCRB_B_ANYALM     6
// Pin pairs handed to the remote sensors
`define MCRB_B_S1_PINS    4
`define MCRB_B_S2_PINS    6
// Counts and widths
`define MCRB_N_ADC        16
`define MCRB_N_DAC        12
`define MCRB_W_CODE       12
`define MCRB_W_IDX        4
`endif

// file: logic/mcrb_reg_bank.v
`timescale 1ns/1ns
`include "mcrb_map.vh"
// What this block does
// - Hold an 8-bit signed ideality correction code, 7Fh largest, 80h smallest.
// - Result registers show a 12-bit read-only value; upper bits zero; reset zero.
// - Channel n result goes to result register n, straight binary single-ended.
// - Differential pairs 0/1 and 2/3 store into registers 0 and 2, two's complement.
// - Twelve readable 12-bit output codes, transferred into each output latch.
// - Twelve 12-bit clear levels, loaded into the output latch on clear.
// - Pin register write: bit 0 drives pin low, bit 1 releases it.
// - Pin register read returns sampled levels of all eight pins.
// - Any reset sets all pin bits to 1, releasing every pin.
// - With remote sensor one enabled, pin bits 4 and 5 are ignored.
// - With remote sensor two enabled, pin bits 6 and 7 are ignored.
// - Main control resets to 2000h with the documented bit layout.
// - Soft convert bit starts a conversion and self-clears once started.
// - Ready flag clears on result read, conversion start, or written zero.
// - Any-alarm flag ORs the alarms, sticks until the status register is read.
// - Repeat mode keeps the sequence running until the bit is cleared.
module mcrb_reg_bank (
  input  wire         i_mclk,
  input  wire         i_nrst,
  input  wire         i_soft_rst,
  input  wire         i_wr,
  input  wire         i_rd,
  input  wire [6:0]   i_addr,
  input  wire [15:0]  i_wdata,
  output reg  [15:0]  o_rdata,
  output reg          o_rvalid,
  input  wire         i_res_wr,
  input  wire [3:0]   i_res_ch,
  input  wire [11:0]  i_res_data,
  input  wire         i_diff01,
  input  wire         i_diff23,
  input  wire         i_conv_started,
  input  wire         i_seq_done,
  input  wire [15:0]  i_alarms,
  input  wire         i_status_rd,
  input  wire         i_out_clear,
  input  wire         i_remote_sensor_one,
  input  wire         i_remote_sensor_two,
  input  wire [7:0]   i_gpio,
  output reg  [7:0]   o_gpio_oe,
  output reg  [7:0]   o_gpio,
  output reg  [7:0]   o_eta_correction,
  output reg          o_repeat_conversion_sel,
  output reg          o_soft_convert_start,
  output reg          o_ref_sel,
  output reg          o_alarm_pin_en,
  output reg          o_result_ready_flag,
  output reg          o_any_alarm_flag,
  output wire [143:0] o_dac_latch
);
  function in_range;
    input [6:0] a;
    input [6:0] lo;
    input [6:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function [3:0] idx_of;
    input [6:0] a;
    input [6:0] base;
    reg   [6:0] d;
    begin
      d = a - base;
      idx_of = d[3:0];
    end
  endfunction

  wire        hit_adc = in_range(i_addr, `MCRB_ADDR_ADC0, `MCRB_ADDR_ADC15);
  wire        hit_dac = in_range(i_addr, `MCRB_ADDR_DAC0, `MCRB_ADDR_DAC11);
  wire        hit_clr = in_range(i_addr, `MCRB_ADDR_CLR0, `MCRB_ADDR_CLR11);
  wire        hit_gpio = (i_addr == `MCRB_ADDR_GPIO);
  wire        hit_ctrl = (i_addr == `MCRB_ADDR_CTRL);
  wire        hit_eta  = (i_addr == `MCRB_ADDR_ETA);
  wire [3:0]  adc_idx  = idx_of(i_addr, `MCRB_ADDR_ADC0);
  wire [3:0]  dac_idx  = hit_clr ? idx_of(i_addr, `MCRB_ADDR_CLR0)
                                 : idx_of(i_addr, `MCRB_ADDR_DAC0);
  wire [11:0] adc_rd;
  wire [11:0] dac_code_rd;
  wire [11:0] output_clear_level_rd;
  wire        rst_any = i_soft_rst;
  reg  [7:0]  pin_bits_q;
  reg         sync_output_load_q;
  reg  [3:0]  wr_ch;
  reg         merge_d;

  // Differential pairs land on the even register of the pair
  always @* begin
    wr_ch = i_res_ch;
    merge_d = 1'b0;
    if (i_diff01 && (i_res_ch[3:1] == 3'h0)) begin
      wr_ch = 4'h0;
      merge_d = 1'b1;
    end else if (i_diff23 && (i_res_ch[3:1] == 3'h1)) begin
      wr_ch = 4'h2;
      merge_d = 1'b1;
    end
  end

  // The converter delivers the pair once; an odd-channel beat is dropped
  wire res_we = i_res_wr && !(merge_d && i_res_ch[0]);

  mcrb_result_bank u_res (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_wr      (res_we),
    .i_wr_ch   (wr_ch),
    .i_wr_data (i_res_data),
    .i_rd_ch   (adc_idx),
    .o_rd_data (adc_rd)
  );

  mcrb_dac_bank u_dac (
    .i_mclk      (i_mclk),
    .i_nrst      (i_nrst),
    .i_code_wr   (i_wr && hit_dac),
    .i_clr_wr    (i_wr && hit_clr),
    .i_idx       (dac_idx),
    .i_wdata     (i_wdata[11:0]),
    .i_load      (sync_output_load_q),
    .i_clear     (i_out_clear),
    .i_rd_idx    (dac_idx),
    .o_code      (dac_code_rd),
    .o_clr_level (output_clear_level_rd),
    .o_latch     (o_dac_latch)
  );

  reg  [7:0]  pin_mask;
  wire [7:0]  pin_eff;

  // Sensor-owned pins stay released regardless of the stored bits
  always @* begin
    pin_mask = 8'h00;
    if (i_remote_sensor_one) begin
      pin_mask[`MCRB_B_S1_PINS +: 2] = 2'b11;
    end
    if (i_remote_sensor_two) begin
      pin_mask[`MCRB_B_S2_PINS +: 2] = 2'b11;
    end
  end

  assign pin_eff = pin_bits_q | pin_mask;

  // Control reset word; each field takes its own bit of it
  localparam [15:0] CTRL_RST = `MCRB_RST_CTRL;

  wire        wr_gpio   = i_wr && hit_gpio;
  wire        wr_eta    = i_wr && hit_eta;
  wire        wr_ctrl   = i_wr && hit_ctrl;
  wire        rd_adc    = i_rd && hit_adc;
  wire        rdy_set   = i_seq_done && !o_repeat_conversion_sel;
  wire        rdy_clr   = rd_adc || i_conv_started ||
                          (wr_ctrl && !i_wdata[`MCRB_B_RDY]) ||
                          o_repeat_conversion_sel;
  wire        alarm_any = |i_alarms;
  reg  [15:0] ctrl_rd;
  reg  [15:0] rdata_d;

  // Pin register; enable high means the pin is pulled low
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_bits_q <= `MCRB_RST_GPIO;
      o_gpio     <= 8'h00;
      o_gpio_oe  <= 8'h00;
    end else if (rst_any) begin
      pin_bits_q <= `MCRB_RST_GPIO;
      o_gpio     <= 8'h00;
      o_gpio_oe  <= 8'h00;
    end else begin
      o_gpio    <= 8'h00;
      o_gpio_oe <= ~pin_eff;
      if (wr_gpio) begin
        pin_bits_q <= i_wdata[7:0];
      end
    end
  end

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_eta_correction <= `MCRB_RST_ETA;
    end else if (rst_any) begin
      o_eta_correction <= `MCRB_RST_ETA;
    end else if (wr_eta) begin
      o_eta_correction <= i_wdata[7:0];
    end
  end

  // Load strobe lives one cycle, so the output latches load only once
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_repeat_conversion_sel <= CTRL_RST[`MCRB_B_REPEAT_CONVERSION_SEL];
      sync_output_load_q                 <= CTRL_RST[`MCRB_B_SYNC_OUTPUT_LOAD];
      o_ref_sel               <= CTRL_RST[`MCRB_B_REFSEL];
      o_alarm_pin_en          <= CTRL_RST[`MCRB_B_ALMEN];
    end else if (rst_any) begin
      o_repeat_conversion_sel <= CTRL_RST[`MCRB_B_REPEAT_CONVERSION_SEL];
      sync_output_load_q                 <= CTRL_RST[`MCRB_B_SYNC_OUTPUT_LOAD];
      o_ref_sel               <= CTRL_RST[`MCRB_B_REFSEL];
      o_alarm_pin_en          <= CTRL_RST[`MCRB_B_ALMEN];
    end else begin
      sync_output_load_q <= 1'b0;
      if (wr_ctrl) begin
        o_repeat_conversion_sel <= i_wdata[`MCRB_B_REPEAT_CONVERSION_SEL];
        o_ref_sel               <= i_wdata[`MCRB_B_REFSEL];
        o_alarm_pin_en          <= i_wdata[`MCRB_B_ALMEN];
        sync_output_load_q                 <= i_wdata[`MCRB_B_SYNC_OUTPUT_LOAD];
      end
    end
  end

  // Start request holds until the converter confirms it began
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_soft_convert_start <= CTRL_RST[`MCRB_B_SOFT_CONVERT_START];
    end else if (rst_any) begin
      o_soft_convert_start <= CTRL_RST[`MCRB_B_SOFT_CONVERT_START];
    end else if (wr_ctrl && i_wdata[`MCRB_B_SOFT_CONVERT_START]) begin
      o_soft_convert_start <= 1'b1;
    end else if (i_conv_started) begin
      o_soft_convert_start <= 1'b0;
    end
  end

  // Set wins over every clear; flag only valid in single-pass mode
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_result_ready_flag <= CTRL_RST[`MCRB_B_RDY];
    end else if (rst_any) begin
      o_result_ready_flag <= CTRL_RST[`MCRB_B_RDY];
    end else if (rdy_set) begin
      o_result_ready_flag <= 1'b1;
    end else if (rdy_clr) begin
      o_result_ready_flag <= 1'b0;
    end
  end

  // A fresh alarm outranks a status read in the same cycle
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_any_alarm_flag <= CTRL_RST[`MCRB_B_ANYALM];
    end else if (rst_any) begin
      o_any_alarm_flag <= CTRL_RST[`MCRB_B_ANYALM];
    end else if (alarm_any) begin
      o_any_alarm_flag <= 1'b1;
    end else if (i_status_rd) begin
      o_any_alarm_flag <= 1'b0;
    end
  end

  // Control word as read back; reserved positions stay zero
  always @* begin
    ctrl_rd                 = 16'h0000;
    ctrl_rd[`MCRB_B_REPEAT_CONVERSION_SEL]  = o_repeat_conversion_sel;
    ctrl_rd[`MCRB_B_SOFT_CONVERT_START]  = o_soft_convert_start;
    ctrl_rd[`MCRB_B_SYNC_OUTPUT_LOAD]  = sync_output_load_q;
    ctrl_rd[`MCRB_B_REFSEL] = o_ref_sel;
    ctrl_rd[`MCRB_B_ALMEN]  = o_alarm_pin_en;
    ctrl_rd[`MCRB_B_RDY]    = o_result_ready_flag;
    ctrl_rd[`MCRB_B_ANYALM] = o_any_alarm_flag;
  end

  always @* begin
    rdata_d = 16'h0000;
    if (hit_adc) begin
      rdata_d = {4'h0, adc_rd};
    end else if (hit_dac) begin
      rdata_d = {4'h0, dac_code_rd};
    end else if (hit_clr) begin
      rdata_d = {4'h0, output_clear_level_rd};
    end else if (hit_gpio) begin
      rdata_d = {8'h00, i_gpio};
    end else if (hit_eta) begin
      rdata_d = {8'h00, o_eta_correction};
    end else if (hit_ctrl) begin
      rdata_d = ctrl_rd;
    end
  end

  // Read data is registered and returns to zero between answers
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else if (i_rd) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rdata_d;
    end else begin
      o_rvalid <= 1'b0;
      o_rdata  <= 16'h0000;
    end
  end
endmodule

// file: logic/mcrb_result_bank.v
`timescale 1ns/1ns
`include "mcrb_map.vh"
module mcrb_result_bank (
  input  wire        i_mclk,
  input  wire        i_nrst,
  input  wire        i_wr,
  input  wire [3:0]  i_wr_ch,
  input  wire [11:0] i_wr_data,
  input  wire [3:0]  i_rd_ch,
  output wire [11:0] o_rd_data
);
  // Per-channel results; converter supplies already formatted codes
  reg [11:0] res_q [0:15];
  integer    k;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < `MCRB_N_ADC; k = k + 1)
        res_q[k] <= `MCRB_RST_CODE;
    end else if (i_wr) begin
      res_q[i_wr_ch] <= i_wr_data;
    end
  end

  assign o_rd_data = res_q[i_rd_ch];
endmodule

// file: tb/mcrb_checker.sv
`timescale 1ns/1ns
module mcrb_checker (
  input wire        i_mclk,
  input wire        i_nrst,
  input wire        i_soft_rst,
  input wire        i_wr,
  input wire        i_rd,
  input wire [6:0]  i_addr,
  input wire        i_seq_done,
  input wire [15:0] i_alarms,
  input wire        i_conv_started,
  input wire        i_status_rd,
  input wire        i_remote_sensor_one,
  input wire        i_remote_sensor_two,
  input wire [15:0] o_rdata,
  input wire        o_rvalid,
  input wire [7:0]  o_gpio_oe,
  input wire [7:0]  o_gpio,
  input wire        o_soft_convert_start,
  input wire        o_result_ready_flag,
  input wire        o_any_alarm_flag
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read not answered");
  a_result_upper: assert property (i_rd && i_addr >= 7'h23 &&
    i_addr <= 7'h32 |=> o_rdata[15:12] == 4'h0) else $error("upper bits");
  a_ready_clear: assert property (i_rd && i_addr == 7'h23 &&
    !i_seq_done |=> !o_result_ready_flag) else $error("ready kept");
  a_pin_reset: assert property (i_soft_rst |=> o_gpio_oe == 8'h00)
    else $error("pins not released");
  a_pins_low: assert property (o_gpio == 8'h00)
    else $error("pin drive level");
  a_sensor_one: assert property (i_remote_sensor_one &&
    $past(i_remote_sensor_one) |-> o_gpio_oe[5:4] == 2'b00)
    else $error("sensor one pins");
  a_sensor_two: assert property (i_remote_sensor_two &&
    $past(i_remote_sensor_two) |-> o_gpio_oe[7:6] == 2'b00)
    else $error("sensor two pins");
  a_conv_clear: assert property (o_soft_convert_start &&
    i_conv_started && !i_wr |=> !o_soft_convert_start)
    else $error("convert bit kept");
  a_alarm_sticky: assert property ((|i_alarms) && !i_soft_rst
    |=> o_any_alarm_flag ##1 (o_any_alarm_flag || $past(i_status_rd) ||
    $past(i_soft_rst))) else $error("alarm not held");
  cover property (i_rd && i_addr == 7'h23 && o_result_ready_flag);
  cover property (o_soft_convert_start && i_conv_started);
  cover property (i_remote_sensor_one && o_gpio_oe != 8'h00);
endmodule
bind mcrb_reg_bank mcrb_checker u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_soft_rst(i_soft_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
  .i_seq_done(i_seq_done), .i_alarms(i_alarms),
  .i_conv_started(i_conv_started), .o_rdata(o_rdata),
  .i_status_rd(i_status_rd),
  .i_remote_sensor_one(i_remote_sensor_one), .o_rvalid(o_rvalid),
  .i_remote_sensor_two(i_remote_sensor_two), .o_gpio_oe(o_gpio_oe),
  .o_gpio(o_gpio), .o_soft_convert_start(o_soft_convert_start),
  .o_result_ready_flag(o_result_ready_flag),
  .o_any_alarm_flag(o_any_alarm_flag));

// file: tb/mcrb_pin_model.sv
`timescale 1ns/1ns
module mcrb_pin_model (
  input  wire [7:0] i_oe,
  input  wire [7:0] i_ext_low,
  output wire [7:0] o_level
);
  // Pull-ups hold released pins high, so a floating pin never reads unknown
  assign o_level = ~(i_oe | i_ext_low);
endmodule

// file: tb/mcrb_reg_bank_tb_top.sv
`timescale 1ns/1ns
`include "mcrb_map.vh"
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module mcrb_reg_bank_tb_top;
  reg          clk, nrst, srst, wr, rd, rw, d01, d23, cs, sd, sr, oc, s1, s2;
  reg  [6:0]   addr;
  reg  [15:0]  wd, al, e;
  reg  [3:0]   rch;
  reg  [11:0]  rdd;
  reg  [7:0]   ext;
  reg  [11:0]  res[16], code[12], clr[12];
  reg  [15:0]  expq[$];
  wire [15:0]  rdat;
  wire         rv, scs, rdy, alm, rep, rsel, aen;
  wire [7:0]   pin, oe, go, eta;
  wire [143:0] lat;
  integer      fail_count = 0, tests_run = 0, seed = 32'hb015fe3e, k;
  mcrb_reg_bank dut (.i_mclk(clk), .i_nrst(nrst), .i_soft_rst(srst),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wd), .o_rdata(rdat),
    .o_rvalid(rv), .i_res_wr(rw), .i_res_ch(rch), .i_res_data(rdd),
    .i_diff01(d01), .i_diff23(d23), .i_conv_started(cs),
    .i_seq_done(sd), .i_alarms(al), .i_status_rd(sr), .i_out_clear(oc),
    .i_remote_sensor_one(s1), .i_remote_sensor_two(s2), .i_gpio(pin),
    .o_gpio_oe(oe), .o_gpio(go), .o_eta_correction(eta),
    .o_repeat_conversion_sel(rep), .o_soft_convert_start(scs),
    .o_ref_sel(rsel), .o_alarm_pin_en(aen), .o_result_ready_flag(rdy),
    .o_any_alarm_flag(alm), .o_dac_latch(lat));
  mcrb_pin_model u_pins (.i_oe(oe), .i_ext_low(ext), .o_level(pin));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr16(input [6:0] a, input [15:0] d);
    @(negedge clk); wr = 1; addr = a; wd = d; @(negedge clk); wr = 0;
  endtask
  task rd16(input [6:0] a, input [15:0] x);
    expq.push_back(x); @(negedge clk); rd = 1; addr = a;
    @(negedge clk); rd = 0;
  endtask
  task res_put(input [3:0] c, input [11:0] v);
    @(negedge clk); rw = 1; rch = c; rdd = v; @(negedge clk); rw = 0;
  endtask
  // Reply watcher: every answer must match the oldest note in order
  always @(negedge clk) if (rv === 1'b1) begin
    `CHK(expq.size() > 0, 1'b1)
    if (expq.size() > 0) begin
      e = expq.pop_front();
      `CHK(rdat, e)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  initial begin
    {nrst, srst, wr, rd, rw, d01, d23, cs, sd, sr, oc, s1, s2} = 0;
    {addr, wd, al, rch, rdd, ext} = 0;
    tick(3); nrst = 1;
    rd16(`MCRB_ADDR_CTRL, `MCRB_RST_CTRL);
    rd16(`MCRB_ADDR_GPIO, 16'h00ff);
    rd16(`MCRB_ADDR_ADC15, 16'h0000);
    rd16(7'h7f, 16'h0000);
    wr16(`MCRB_ADDR_ETA, 16'hff80); rd16(`MCRB_ADDR_ETA, 16'h0080);
    `CHK(eta, 8'h80)
    wr16(`MCRB_ADDR_CTRL, 16'hc0c0); rd16(`MCRB_ADDR_CTRL, 0);
    `CHK(rep, 1'b0)
    for (k = 0; k < 12; k++) begin
      code[k] = $random(seed); clr[k] = $random(seed);
      wr16(`MCRB_ADDR_DAC0 + k, {4'hf, code[k]});
      wr16(`MCRB_ADDR_CLR0 + k, {4'ha, clr[k]});
      rd16(`MCRB_ADDR_DAC0 + k, {4'h0, code[k]});
      rd16(`MCRB_ADDR_CLR0 + k, {4'h0, clr[k]});
    end
    oc = 1; tick(2);
    for (k = 0; k < 12; k++) `CHK(lat[12*k +: 12], clr[k])
    oc = 0; wr16(`MCRB_ADDR_CTRL, 16'h0800); tick(2);
    for (k = 0; k < 12; k++) `CHK(lat[12*k +: 12], code[k])
    for (k = 0; k < 16; k++) begin
      res[k] = $random(seed); res_put(k, res[k]);
    end
    sd = 1; tick(1); sd = 0; tick(1);
    `CHK(rdy, 1'b1)
    for (k = 0; k < 16; k++) rd16(`MCRB_ADDR_ADC0 + k, {4'h0, res[k]});
    tick(1); `CHK(rdy, 1'b0)
    d01 = 1; res_put(1, ~res[1]); res_put(0, 12'h800);
    rd16(`MCRB_ADDR_ADC0 + 1, {4'h0, res[1]});
    rd16(`MCRB_ADDR_ADC0, 16'h0800);
    d23 = 1; res_put(3, ~res[3]); res_put(2, 12'h7ff);
    rd16(`MCRB_ADDR_ADC0 + 3, {4'h0, res[3]});
    rd16(`MCRB_ADDR_ADC0 + 2, 16'h07ff);
    d01 = 0; d23 = 0; wr16(`MCRB_ADDR_GPIO, 16'hff5a); tick(1);
    `CHK(oe, 8'ha5)
    `CHK(go, 8'h00)
    ext = 8'h02; tick(3); rd16(`MCRB_ADDR_GPIO, 16'h0058);
    s1 = 1; tick(2); `CHK(oe[5:4], 2'b00)
    s2 = 1; tick(2); `CHK(oe[7:6], 2'b00)
    {s1, s2, ext} = 0; al = 16'h0100; tick(1); al = 0; tick(2);
    `CHK(alm, 1'b1)
    sr = 1; tick(1); sr = 0; tick(1); `CHK(alm, 1'b0)
    sd = 1; tick(1); sd = 0; wr16(`MCRB_ADDR_CTRL, 16'h0080);
    `CHK(rdy, 1'b1)
    wr16(`MCRB_ADDR_CTRL, 16'h0000); `CHK(rdy, 1'b0)
    wr16(`MCRB_ADDR_CTRL, 16'h1000); tick(2); `CHK(scs, 1'b1)
    cs = 1; tick(1); cs = 0; tick(1); `CHK(scs, 1'b0)
    rd16(`MCRB_ADDR_CTRL, 16'h0000);
    wr16(`MCRB_ADDR_CTRL, 16'h2600); `CHK(rep, 1'b1)
    `CHK(rsel, 1'b1)
    `CHK(aen, 1'b1)
    sd = 1; tick(1); sd = 0; tick(1); `CHK(rdy, 1'b0)
    wr16(`MCRB_ADDR_GPIO, 0); srst = 1; tick(1); srst = 0;
    `CHK(oe, 8'h00)
    `CHK(rsel, 1'b0)
    rd16(`MCRB_ADDR_CTRL, `MCRB_RST_CTRL);
    tick(4); `CHK(expq.size(), 0)
    end_sim;
  end
endmodule
